// *** rtl/imm_cfg.svh ***
`ifndef IMM_CFG_SVH
`define IMM_CFG_SVH

`define IMM_A_CTRL 8'h00
`define IMM_A_STATUS 8'h04
`define IMM_A_SCAN_LBA 8'h08
`define IMM_A_MAX_LBA 8'h0C
`define IMM_A_FORMAT 8'h10
`define IMM_A_CAP16 8'h14
`define IMM_A_INQ 8'h18
`define IMM_A_LOG 8'h1C

`define IMM_B_SCAN_EN 0
`define IMM_B_ARRE 1
`define IMM_B_AWRE 2
`define IMM_B_RC 3
`define IMM_B_IWV_EN 4
`define IMM_CTRL_RST 5'h17
`define IMM_MAX_LBA_RST 32'h0000_FFFF

`define IMM_FMT_OPC 8'h04
`define IMM_FMT_T1 8'h90
`define IMM_FMT_T2 8'hD0
`define IMM_FMT_HDR 16'h00A0
`define IMM_FMT_PI_BIT 7

`define IMM_PHYS_PI 16'h0208
`define IMM_PHYS_PLAIN 16'h0200
`define IMM_INQ_VAL 32'h0000_003F

`define IMM_DEFER_N 4
`define IMM_IWV_N 4

`define IMM_CLK_KHZ 32'h0001_E848
`define IMM_FIRST_IDLE_MS 32'h0000_0005
`define IMM_LATER_IDLE_MS 32'h0000_01F4
`define IMM_RESUME_MS 32'h0000_0001
`define IMM_BURST_CYC 32'h0001_0000
`endif

// *** rtl/imm_pkg.sv ***
package imm_pkg;
    typedef enum logic [1:0] {IMM_T0 = 2'h0, IMM_T1 = 2'h1, IMM_T2 = 2'h2} imm_pi_t;
    typedef enum logic [1:0] {IMM_L10 = 2'h0, IMM_L16 = 2'h1, IMM_L32 = 2'h2} imm_len_t;
    typedef enum logic [2:0] {IMM_OP_NONE = 3'h0, IMM_OP_READ = 3'h1, IMM_OP_WRITE = 3'h2,
        IMM_OP_VERIFY = 3'h3, IMM_OP_REMAP = 3'h4, IMM_OP_COMPARE = 3'h5} imm_op_t;
    typedef enum logic [1:0] {IMM_SN_OK = 2'h0, IMM_SN_INVALID = 2'h1, IMM_SN_PREV_FAIL = 2'h2} imm_sense_t;
    typedef struct packed {
        logic write;
        imm_len_t len;
        logic prot_nz;
        logic [31:0] lba;
    } imm_cmd_t;
    typedef struct packed {
        logic req;
        imm_op_t op;
        logic [31:0] lba;
    } imm_media_req_t;
    typedef struct packed {
        logic done;
        logic unreadable;
        logic recovered;
        logic recovering;
        logic fail;
    } imm_media_rsp_t;
endpackage

// *** rtl/imm_top.sv ***
`include "imm_cfg.svh"

module imm_top #(
    parameter int unsigned FIRST_IDLE_CYC = `IMM_FIRST_IDLE_MS * `IMM_CLK_KHZ,
    parameter int unsigned LATER_IDLE_CYC = `IMM_LATER_IDLE_MS * `IMM_CLK_KHZ,
    parameter int unsigned RESUME_CYC = `IMM_RESUME_MS * `IMM_CLK_KHZ,
    parameter int unsigned BURST_CYC = `IMM_BURST_CYC
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_cmd_valid,
    input wire imm_pkg::imm_cmd_t i_cmd,
    output logic o_cmd_ready,
    output logic o_cmd_done,
    output imm_pkg::imm_sense_t o_cmd_sense,
    output logic o_pi_xfer,
    output logic o_pi_gen,
    output logic o_format,
    output imm_pkg::imm_media_req_t o_media,
    output logic o_media_abort,
    input wire imm_pkg::imm_media_rsp_t i_media
);
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01, ST_SCAN = 8'h02, ST_RESUME = 8'h04, ST_HOST = 8'h08,
        ST_FIX_WR = 8'h10, ST_FIX_VER = 8'h20, ST_REMAP = 8'h40, ST_VERIFY = 8'h80
    } imm_state_t;

    imm_state_t state;
    logic [4:0] ctrl;
    logic [31:0] max_lba;
    logic [31:0] scan_lba;
    imm_pkg::imm_pi_t pi_type;
    logic first_done;
    logic [31:0] idle_cnt;
    logic [31:0] wait_cnt;
    logic cmd_pend;
    imm_pkg::imm_cmd_t cmd_q;
    logic issued;
    logic [31:0] fix_lba;
    logic fix_host;
    logic [15:0] log_cnt;
    logic [`IMM_DEFER_N-1:0] defer_v;
    logic [31:0] defer_lba [`IMM_DEFER_N];
    logic [`IMM_IWV_N-1:0] iwv_v;
    logic [31:0] iwv_lba [`IMM_IWV_N];

    logic realloc_ok;
    logic idle_due;
    logic fmt_ev;
    imm_pkg::imm_pi_t fmt_type;
    logic fmt_ok;
    logic mark_ev;
    logic unmark_ev;
    logic push_ev;
    logic pop_ev;

    function automatic logic [`IMM_DEFER_N:0] defer_find(input logic [31:0] lba,
        input logic [`IMM_DEFER_N-1:0] v, input logic [31:0] t [`IMM_DEFER_N]);
        logic [`IMM_DEFER_N:0] r;
        r = '0;
        for (int i = 0; i < `IMM_DEFER_N; i++) begin
            if (v[i] && t[i] == lba) begin
                r = {1'b1, `IMM_DEFER_N'(1 << i)};
            end
        end
        return r;
    endfunction

    function automatic logic cmd_bad(input imm_pkg::imm_cmd_t c, input imm_pkg::imm_pi_t t);
        logic b;
        b = 1'b0;
        unique case (t)
            imm_pkg::IMM_T0: b = c.prot_nz;
            imm_pkg::IMM_T1: b = (c.len == imm_pkg::IMM_L32);
            imm_pkg::IMM_T2: b = (c.len != imm_pkg::IMM_L32) && c.prot_nz;
            default: b = 1'b1;
        endcase
        return b;
    endfunction

    // Reallocation needs a read or write enable and is vetoed by recovered-error reporting.
    assign realloc_ok = (ctrl[`IMM_B_ARRE] || ctrl[`IMM_B_AWRE]) && !ctrl[`IMM_B_RC];
    assign idle_due = idle_cnt >= (first_done ? LATER_IDLE_CYC : FIRST_IDLE_CYC);

    always_comb begin
        fmt_ev = 1'b0;
        fmt_ok = 1'b0;
        fmt_type = imm_pkg::IMM_T0;
        if (i_wr && i_addr == `IMM_A_FORMAT && i_wdata[31:24] == `IMM_FMT_OPC) begin
            fmt_ev = 1'b1;
            if (!i_wdata[16 + `IMM_FMT_PI_BIT]) begin
                fmt_ok = 1'b1;
            end else if (i_wdata[15:0] == `IMM_FMT_HDR && i_wdata[23:16] == `IMM_FMT_T1) begin
                fmt_ok = 1'b1;
                fmt_type = imm_pkg::IMM_T1;
            end else if (i_wdata[15:0] == `IMM_FMT_HDR && i_wdata[23:16] == `IMM_FMT_T2) begin
                fmt_ok = 1'b1;
                fmt_type = imm_pkg::IMM_T2;
            end
        end
    end

    always_comb begin
        mark_ev = state == ST_SCAN && i_media.done && i_media.unreadable;
        unmark_ev = (state == ST_FIX_VER && i_media.done && !i_media.fail)
            || (state == ST_REMAP && i_media.done);
        push_ev = state == ST_HOST && issued && i_media.done && cmd_q.write && ctrl[`IMM_B_IWV_EN];
        pop_ev = state == ST_VERIFY && i_media.done;
    end

    // Software control: steering bits, media limit and the one protection type held.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ctrl <= `IMM_CTRL_RST;
            max_lba <= `IMM_MAX_LBA_RST;
            pi_type <= imm_pkg::IMM_T0;
            o_format <= 1'b0;
        end else begin
            o_format <= fmt_ev && fmt_ok;
            if (i_wr && i_addr == `IMM_A_CTRL) begin
                ctrl <= i_wdata[4:0];
            end
            if (i_wr && i_addr == `IMM_A_MAX_LBA) begin
                max_lba <= i_wdata;
            end
            if (fmt_ev && fmt_ok) begin
                pi_type <= fmt_type;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= '0;
            if (i_rd) begin
                unique case (i_addr)
                    `IMM_A_CTRL: o_rdata <= {27'h0, ctrl};
                    `IMM_A_STATUS: o_rdata <= {16'h0, 4'h0, iwv_v, state};
                    `IMM_A_SCAN_LBA: o_rdata <= scan_lba;
                    `IMM_A_MAX_LBA: o_rdata <= max_lba;
                    `IMM_A_CAP16: o_rdata <= {(pi_type == imm_pkg::IMM_T0) ? `IMM_PHYS_PLAIN : `IMM_PHYS_PI,
                        12'h0, pi_type != imm_pkg::IMM_T0, 1'b0, pi_type};
                    `IMM_A_INQ: o_rdata <= `IMM_INQ_VAL;
                    `IMM_A_LOG: o_rdata <= {log_cnt, 12'h0, defer_v};
                    default: o_rdata <= '0;
                endcase
            end
        end
    end

    // Idle time counts only while nothing is pending, so any command restarts the wait.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            idle_cnt <= '0;
        end else if (state != ST_IDLE || cmd_pend || i_cmd_valid) begin
            idle_cnt <= '0;
        end else if (!idle_due) begin
            idle_cnt <= idle_cnt + 32'h1;
        end
    end

    generate
        for (genvar g = 0; g < `IMM_DEFER_N; g++) begin : g_defer
            always_ff @(posedge i_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    defer_v[g] <= 1'b0;
                    defer_lba[g] <= '0;
                end else if (fmt_ev && fmt_ok) begin
                    defer_v[g] <= 1'b0;
                end else if (unmark_ev && defer_v[g] && defer_lba[g] == fix_lba) begin
                    defer_v[g] <= 1'b0;
                end else if (mark_ev && !defer_find(scan_lba, defer_v, defer_lba)[`IMM_DEFER_N]
                        && (g == 0 || &defer_v[(g > 0 ? g - 1 : 0):0]) && !defer_v[g]) begin
                    defer_v[g] <= 1'b1;
                    defer_lba[g] <= scan_lba;
                end
            end
        end
        for (genvar g = 0; g < `IMM_IWV_N; g++) begin : g_iwv
            always_ff @(posedge i_clk or negedge i_resetn) begin
                if (!i_resetn) begin
                    iwv_v[g] <= 1'b0;
                    iwv_lba[g] <= '0;
                end else if (fmt_ev && fmt_ok) begin
                    iwv_v[g] <= 1'b0;
                end else if (pop_ev && g == 0) begin
                    iwv_v[g] <= 1'b0;
                end else if (push_ev && !iwv_v[g] && (g == 0 || &iwv_v[(g > 0 ? g - 1 : 0):0])) begin
                    iwv_v[g] <= 1'b1;
                    iwv_lba[g] <= cmd_q.lba;
                end
            end
        end
    endgenerate

    // Sequencer for scan, host service, repair and idle read-back.
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= ST_IDLE;
            scan_lba <= '0;
            first_done <= 1'b0;
            wait_cnt <= '0;
            cmd_pend <= 1'b0;
            cmd_q <= '0;
            issued <= 1'b0;
            fix_lba <= '0;
            fix_host <= 1'b0;
            log_cnt <= '0;
            o_cmd_ready <= 1'b0;
            o_cmd_done <= 1'b0;
            o_cmd_sense <= imm_pkg::IMM_SN_OK;
            o_pi_xfer <= 1'b0;
            o_pi_gen <= 1'b0;
            o_media <= '0;
            o_media_abort <= 1'b0;
        end else begin
            o_cmd_done <= 1'b0;
            o_media_abort <= 1'b0;
            o_cmd_ready <= !cmd_pend && !(i_cmd_valid && o_cmd_ready);
            if (i_cmd_valid && o_cmd_ready) begin
                cmd_pend <= 1'b1;
                cmd_q <= i_cmd;
            end
            if (fmt_ev && fmt_ok) begin
                scan_lba <= '0;
            end
            unique case (state)
                ST_IDLE: begin
                    o_media <= '0;
                    if (cmd_pend) begin
                        state <= ST_HOST;
                        issued <= 1'b0;
                    end else if (idle_due && iwv_v[0] && !fmt_ev) begin
                        state <= ST_VERIFY;
                        o_media <= {1'b1, imm_pkg::IMM_OP_COMPARE, iwv_lba[0]};
                    end else if (idle_due && ctrl[`IMM_B_SCAN_EN] && !fmt_ev) begin
                        state <= ST_SCAN;
                        first_done <= 1'b1;
                        wait_cnt <= '0;
                        o_media <= {1'b1, imm_pkg::IMM_OP_READ, scan_lba};
                    end
                end
                ST_SCAN: begin
                    wait_cnt <= wait_cnt + 32'h1;
                    if (i_media.done) begin
                        scan_lba <= (scan_lba >= max_lba) ? '0 : scan_lba + 32'h1;
                        o_media <= '0;
                        if (i_media.unreadable || i_media.recovered) begin
                            log_cnt <= log_cnt + 16'h1;
                        end
                        if (i_media.recovered && ctrl[`IMM_B_ARRE] && !ctrl[`IMM_B_RC]) begin
                            state <= ST_REMAP;
                            fix_lba <= scan_lba;
                            fix_host <= 1'b0;
                            o_media <= {1'b1, imm_pkg::IMM_OP_REMAP, scan_lba};
                        end else if (cmd_pend) begin
                            state <= ST_RESUME;
                            wait_cnt <= '0;
                        end else if (wait_cnt >= BURST_CYC) begin
                            state <= ST_IDLE;
                        end else begin
                            o_media <= {1'b1, imm_pkg::IMM_OP_READ,
                                (scan_lba >= max_lba) ? 32'h0 : scan_lba + 32'h1};
                        end
                    end else if (cmd_pend && !i_media.recovering) begin
                        // The block in flight is not counted, so the scan picks it up again later.
                        state <= ST_RESUME;
                        o_media_abort <= 1'b1;
                        o_media <= '0;
                        wait_cnt <= '0;
                    end
                end
                ST_RESUME: begin
                    wait_cnt <= wait_cnt + 32'h1;
                    if (wait_cnt + 32'h1 >= RESUME_CYC) begin
                        state <= ST_HOST;
                        issued <= 1'b0;
                    end
                end
                ST_HOST: begin
                    if (!issued) begin
                        if (cmd_bad(cmd_q, pi_type)) begin
                            state <= ST_IDLE;
                            cmd_pend <= 1'b0;
                            o_cmd_done <= 1'b1;
                            o_cmd_sense <= imm_pkg::IMM_SN_INVALID;
                        end else if (cmd_q.write && defer_find(cmd_q.lba, defer_v, defer_lba)[`IMM_DEFER_N]
                                && realloc_ok) begin
                            state <= ST_FIX_WR;
                            fix_lba <= cmd_q.lba;
                            fix_host <= 1'b1;
                            o_media <= {1'b1, imm_pkg::IMM_OP_WRITE, cmd_q.lba};
                        end else if (cmd_q.write && defer_find(cmd_q.lba, defer_v, defer_lba)[`IMM_DEFER_N]
                                && !ctrl[`IMM_B_ARRE] && !ctrl[`IMM_B_AWRE]) begin
                            state <= ST_IDLE;
                            cmd_pend <= 1'b0;
                            o_cmd_done <= 1'b1;
                            o_cmd_sense <= imm_pkg::IMM_SN_PREV_FAIL;
                        end else begin
                            issued <= 1'b1;
                            o_pi_xfer <= pi_type != imm_pkg::IMM_T0 && cmd_q.prot_nz;
                            o_pi_gen <= pi_type != imm_pkg::IMM_T0;
                            o_media <= {1'b1, cmd_q.write ? imm_pkg::IMM_OP_WRITE : imm_pkg::IMM_OP_READ, cmd_q.lba};
                        end
                    end else if (i_media.done) begin
                        state <= ST_IDLE;
                        cmd_pend <= 1'b0;
                        issued <= 1'b0;
                        o_media <= '0;
                        o_pi_xfer <= 1'b0;
                        o_pi_gen <= 1'b0;
                        o_cmd_done <= 1'b1;
                        o_cmd_sense <= imm_pkg::IMM_SN_OK;
                    end
                end
                ST_FIX_WR: begin
                    if (i_media.done) begin
                        state <= ST_FIX_VER;
                        o_media <= {1'b1, imm_pkg::IMM_OP_VERIFY, fix_lba};
                    end
                end
                ST_FIX_VER: begin
                    if (i_media.done && i_media.fail) begin
                        state <= ST_REMAP;
                        o_media <= {1'b1, imm_pkg::IMM_OP_REMAP, fix_lba};
                    end else if (i_media.done) begin
                        state <= ST_IDLE;
                        o_media <= '0;
                        if (fix_host) begin
                            cmd_pend <= 1'b0;
                            o_cmd_done <= 1'b1;
                            o_cmd_sense <= imm_pkg::IMM_SN_OK;
                        end
                    end
                end
                ST_REMAP: begin
                    if (i_media.done) begin
                        state <= (cmd_pend && !fix_host) ? ST_RESUME : ST_IDLE;
                        wait_cnt <= '0;
                        o_media <= '0;
                        if (fix_host) begin
                            cmd_pend <= 1'b0;
                            o_cmd_done <= 1'b1;
                            o_cmd_sense <= imm_pkg::IMM_SN_OK;
                        end
                    end
                end
                ST_VERIFY: begin
                    if (i_media.done && i_media.fail) begin
                        state <= ST_FIX_WR;
                        fix_lba <= iwv_lba[0];
                        fix_host <= 1'b0;
                        o_media <= {1'b1, imm_pkg::IMM_OP_WRITE, iwv_lba[0]};
                    end else if (i_media.done) begin
                        state <= ST_IDLE;
                        o_media <= '0;
                    end
                end
            endcase
        end
    end
endmodule

// *** test/imm_media_model.sv ***
module imm_media_model (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire imm_pkg::imm_media_req_t i_media,
    input wire logic i_abort,
    input wire logic [3:0] i_delay,
    input wire logic [31:0] i_bad_lba,
    input wire logic i_fail,
    output imm_pkg::imm_media_rsp_t o_rsp
);
    logic [3:0] cnt;
    logic hit;

    // An aborted read never completes, so a late done cannot be mistaken for the next operation.
    assign hit = i_media.req && !i_abort && cnt == i_delay;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt <= 4'h0;
        end else if (!i_media.req || i_abort || hit) begin
            cnt <= 4'h0;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end

    always_comb begin
        o_rsp = '0;
        o_rsp.done = hit;
        o_rsp.unreadable = hit && i_media.op == imm_pkg::IMM_OP_READ && i_media.lba == i_bad_lba;
        o_rsp.fail = hit && i_fail && (i_media.op == imm_pkg::IMM_OP_VERIFY || i_media.op == imm_pkg::IMM_OP_COMPARE);
    end
endmodule

// *** test/imm_top_chk.sv ***
`include "imm_cfg.svh"

module imm_top_chk (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic i_cmd_valid,
    input wire imm_pkg::imm_cmd_t i_cmd,
    input wire logic o_cmd_ready,
    input wire logic o_cmd_done,
    input wire imm_pkg::imm_sense_t o_cmd_sense,
    input wire logic o_pi_xfer,
    input wire logic o_pi_gen,
    input wire logic o_format,
    input wire imm_pkg::imm_media_req_t o_media,
    input wire logic o_media_abort,
    input wire imm_pkg::imm_media_rsp_t i_media
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    sequence s_accept;
        i_cmd_valid && o_cmd_ready;
    endsequence
    sequence s_finish;
        ##[1:200] o_cmd_done;
    endsequence

    chk_cmd_answer: assert property (s_accept |-> s_finish) else $error("command not answered");
    chk_ready_wait: assert property (s_accept |=> !o_cmd_ready until o_cmd_done) else $error("second command taken");
    chk_done_pulse: assert property (o_cmd_done |=> !o_cmd_done) else $error("done held too long");
    chk_abort_cause: assert property (o_media_abort |-> $past(o_media.req) && $past(o_media.op) == imm_pkg::IMM_OP_READ
        && !$past(i_media.recovering)) else $error("abort without scan read");
    chk_media_hold: assert property (o_media.req && !i_media.done |=> (o_media.req && $stable(o_media.lba))
        || o_media_abort) else $error("media request dropped");
    chk_format_cause: assert property (o_format |-> $past(i_wr) && $past(i_addr) == `IMM_A_FORMAT
        && $past(i_wdata[31:24]) == `IMM_FMT_OPC) else $error("format without format write");
    chk_pi_needs_prot: assert property (o_pi_xfer |-> o_pi_gen) else $error("protection sent unformatted");
    chk_inq_value: assert property ($past(i_rd) && $past(i_addr) == `IMM_A_INQ |-> o_rdata == `IMM_INQ_VAL)
        else $error("inquiry word wrong");
    chk_cap_type: assert property ($past(i_rd) && $past(i_addr) == `IMM_A_CAP16 |-> o_rdata[1:0] != 2'h3)
        else $error("type three reported");
    chk_cap_size: assert property ($past(i_rd) && $past(i_addr) == `IMM_A_CAP16
        |-> o_rdata[31:16] == (o_rdata[3] ? `IMM_PHYS_PI : `IMM_PHYS_PLAIN)) else $error("sector size wrong");
endmodule

bind imm_top imm_top_chk u_chk (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
    .o_cmd_ready(o_cmd_ready), .o_cmd_done(o_cmd_done), .o_cmd_sense(o_cmd_sense), .o_pi_xfer(o_pi_xfer),
    .o_pi_gen(o_pi_gen), .o_format(o_format), .o_media(o_media), .o_media_abort(o_media_abort), .i_media(i_media));

// *** test/imm_top_bench.sv ***
`include "imm_cfg.svh"

module imm_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned FIRST = 20;
    localparam int unsigned RESUME = 5;
    typedef struct {
        logic [1:0] kind;
        logic [7:0] addr;
        logic [31:0] data;
        imm_pkg::imm_cmd_t cmd;
    } imm_row_t;
    logic i_clk, i_resetn, i_wr, i_rd, i_cmd_valid, o_cmd_ready, o_cmd_done, o_pi_xfer, o_pi_gen, o_format;
    logic o_media_abort, fail, seen_xfer, seen_gen, seen_abort;
    logic [7:0] i_addr;
    logic [31:0] i_wdata, o_rdata, v, lba0, w;
    imm_pkg::imm_cmd_t i_cmd;
    imm_pkg::imm_sense_t o_cmd_sense;
    imm_pkg::imm_media_req_t o_media;
    imm_pkg::imm_media_rsp_t i_media;
    imm_pkg::imm_op_t ops[$];
    imm_row_t rows[$];
    int error_cnt, total_checks, n, t1, t2;

    imm_top #(.FIRST_IDLE_CYC(FIRST), .LATER_IDLE_CYC(50), .RESUME_CYC(RESUME), .BURST_CYC(8)) dut (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready),
        .o_cmd_done(o_cmd_done), .o_cmd_sense(o_cmd_sense), .o_pi_xfer(o_pi_xfer), .o_pi_gen(o_pi_gen),
        .o_format(o_format), .o_media(o_media), .o_media_abort(o_media_abort), .i_media(i_media));
    imm_media_model u_media (.i_clk(i_clk), .i_resetn(i_resetn), .i_media(o_media), .i_abort(o_media_abort),
        .i_delay(4'h6), .i_bad_lba(32'h0000_0003), .i_fail(fail), .o_rsp(i_media));

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    // All reads, scan and host alike, are left out of the log so write, verify and remap sequences stay easy to compare.
    always @(negedge i_clk) begin
        if (o_media.req === 1'b1 && i_media.done === 1'b1 && o_media.op !== imm_pkg::IMM_OP_READ) begin
            ops.push_back(o_media.op);
        end
        seen_xfer = seen_xfer | (o_pi_xfer === 1'b1);
        seen_gen = seen_gen | (o_pi_gen === 1'b1);
        seen_abort = seen_abort | (o_media_abort === 1'b1);
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        d = o_rdata;
    endtask

    // Returns latency from acceptance to done, and {gen, xfer, 00, sense}.
    task automatic host(input imm_pkg::imm_cmd_t c, output int lat, output logic [31:0] r);
        int k;
        k = 0;
        @(posedge i_clk);
        i_cmd_valid <= 1'b1;
        i_cmd <= c;
        @(negedge i_clk);
        while (o_cmd_ready !== 1'b1 && k < 300) begin
            @(negedge i_clk);
            k++;
        end
        @(posedge i_clk);
        i_cmd_valid <= 1'b0;
        ops.delete();
        {seen_xfer, seen_gen, seen_abort} = 3'h0;
        lat = 0;
        @(negedge i_clk);
        while (o_cmd_done !== 1'b1 && lat < 300) begin
            @(negedge i_clk);
            lat++;
        end
        r = {26'h0, seen_gen, seen_xfer, 2'h0, o_cmd_sense};
    endtask

    task automatic wait_scan(input logic [31:0] skip);
        n = 0;
        while (!(o_media.req === 1'b1 && o_media.op === imm_pkg::IMM_OP_READ && o_media.lba !== skip) && n < 400) begin
            @(negedge i_clk);
            n++;
        end
    endtask

    function automatic void rr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] k = 2'h0);
        rows.push_back('{k, a, e, '{1'b0, imm_pkg::IMM_L10, 1'b0, 32'h0000_0005}});
    endfunction

    function automatic void cm(input imm_pkg::imm_len_t l, input logic p, input logic [31:0] e);
        rows.push_back('{2'h2, 8'h00, e, '{1'b0, l, p, 32'h0000_0005}});
    endfunction

    task automatic summarize();
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_clk);
        error_cnt++;
        summarize();
    end

    initial begin
        {i_resetn, i_wr, i_rd, i_cmd_valid, fail, i_addr, i_wdata, i_cmd} = '0;
        repeat (2) @(posedge i_clk);
        i_resetn <= 1'b1;
        @(negedge i_clk);
        wait_scan(32'hFFFF_FFFF);
        cmp({31'h0, n + 3 >= FIRST && n <= FIRST + 3}, 32'h1);
        lba0 = o_media.lba;
        wait_scan(lba0);
        cmp(o_media.lba, lba0 + 32'h1);
        host('{1'b0, imm_pkg::IMM_L10, 1'b0, 32'h0000_0005}, t1, v);
        cmp({31'h0, seen_abort}, 32'h1);
        host('{1'b0, imm_pkg::IMM_L10, 1'b0, 32'h0000_0005}, t2, v);
        cmp(t1 - t2, RESUME);
        wait_scan(32'hFFFF_FFFF);
        cmp(o_media.lba, lba0 + 32'h1);
        rr(`IMM_A_CTRL, `IMM_CTRL_RST);
        rr(`IMM_A_MAX_LBA, `IMM_MAX_LBA_RST);
        rr(`IMM_A_INQ, `IMM_INQ_VAL);
        rr(`IMM_A_CAP16, 32'h0200_0000);
        rr(8'h20, 32'h0);
        rr(`IMM_A_INQ, 32'h0, 2'h1);
        rr(`IMM_A_INQ, `IMM_INQ_VAL);
        rr(`IMM_A_MAX_LBA, 32'h7, 2'h1);
        rr(`IMM_A_MAX_LBA, 32'h7);
        cm(imm_pkg::IMM_L10, 1'b0, 32'h00);
        cm(imm_pkg::IMM_L16, 1'b1, 32'h01);
        rr(`IMM_A_FORMAT, 32'h0490_00A0, 2'h1);
        rr(`IMM_A_CAP16, 32'h0208_0009);
        cm(imm_pkg::IMM_L16, 1'b1, 32'h30);
        cm(imm_pkg::IMM_L32, 1'b0, 32'h01);
        cm(imm_pkg::IMM_L10, 1'b0, 32'h20);
        rr(`IMM_A_FORMAT, 32'h04D0_00A0, 2'h1);
        rr(`IMM_A_CAP16, 32'h0208_000A);
        cm(imm_pkg::IMM_L32, 1'b1, 32'h30);
        cm(imm_pkg::IMM_L16, 1'b1, 32'h01);
        cm(imm_pkg::IMM_L10, 1'b0, 32'h20);
        rr(`IMM_A_FORMAT, 32'h04D0_00B0, 2'h1);
        rr(`IMM_A_FORMAT, 32'h0590_00A0, 2'h1);
        rr(`IMM_A_CAP16, 32'h0208_000A);
        rr(`IMM_A_FORMAT, 32'h0400_0000, 2'h1);
        rr(`IMM_A_CAP16, 32'h0200_0000);
        foreach (rows[i]) begin
            if (rows[i].kind == 2'h1) begin
                reg_wr(rows[i].addr, rows[i].data);
            end else begin
                if (rows[i].kind == 2'h0) begin
                    reg_rd(rows[i].addr, v);
                end else begin
                    host(rows[i].cmd, t1, v);
                end
                cmp(v, rows[i].data);
            end
        end
        n = 0;
        v = 32'h0;
        while (v[3:0] == 4'h0 && n < 100) begin
            reg_rd(`IMM_A_LOG, v);
            n++;
        end
        cmp({31'h0, |v[3:0]}, 32'h1);
        reg_wr(`IMM_A_CTRL, 32'h0000_0011);
        host('{1'b1, imm_pkg::IMM_L10, 1'b0, 32'h0000_0003}, t1, v);
        cmp(v[1:0], imm_pkg::IMM_SN_PREV_FAIL);
        reg_wr(`IMM_A_CTRL, `IMM_CTRL_RST);
        fail <= 1'b1;
        host('{1'b1, imm_pkg::IMM_L10, 1'b0, 32'h0000_0003}, t1, v);
        w = 32'h0;
        foreach (ops[i]) w = {w[27:0], 1'b0, ops[i]};
        cmp({w[11:0], 18'h0, v[1:0]}, {12'h234, 18'h0, imm_pkg::IMM_SN_OK});
        host('{1'b1, imm_pkg::IMM_L10, 1'b0, 32'h0000_0005}, t1, v);
        ops.delete();
        n = 0;
        while (ops.size() < 4 && n < 600) begin
            @(negedge i_clk);
            n++;
        end
        w = 32'h0;
        foreach (ops[i]) w = {w[27:0], 1'b0, ops[i]};
        cmp(w, 32'h0000_5234);
        reg_wr(`IMM_A_CTRL, 32'h0);
        @(posedge i_clk);
        i_resetn <= 1'b0;
        @(negedge i_clk);
        cmp({31'h0, o_cmd_ready}, 32'h0);
        repeat (2) @(posedge i_clk);
        i_resetn <= 1'b1;
        reg_rd(`IMM_A_CTRL, v);
        cmp(v, `IMM_CTRL_RST);
        summarize();
    end
endmodule
